// ===== common/seq_pkg.sv
/*
  Shared constants and carrier types for the shift register sequencer.
  Assumes a single 50 MHz core clock and AXI4-Lite register access.
*/
package seq_pkg;

  localparam int unsigned CLK_HZ         = 50000000;
  localparam int unsigned ADDR_W         = 8;
  localparam int unsigned STAGES         = 128;
  localparam int unsigned SAMPLES        = 256;

  // Register byte offsets.
  localparam logic [7:0] CTRL_OFS        = 8'h00;
  localparam logic [7:0] STATUS_OFS      = 8'h04;
  localparam logic [7:0] COUNT_OFS       = 8'h08;

  // Control register fields.
  localparam int unsigned CTRL_RANGE_LSB = 0;
  localparam int unsigned CTRL_DIRECT_BIT = 2;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;

  // Time base range selector codes written by software.
  localparam logic [1:0] RANGE_SLOW      = 2'h0;
  localparam logic [1:0] RANGE_500N      = 2'h1;
  localparam logic [1:0] RANGE_200N      = 2'h2;

  // Trim select codes, high bit then low bit.
  localparam logic [1:0] TRIM_SLOW       = 2'h0;
  localparam logic [1:0] TRIM_500N       = 2'h1;
  localparam logic [1:0] TRIM_200N       = 2'h2;

  // Output multiplexer address positions.
  localparam logic [1:0] MUX_POS_HOLD    = 2'h1;
  localparam logic [1:0] MUX_POS_REF     = 2'h2;
  localparam logic [1:0] MUX_POS_INT     = 2'h3;

  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;

  typedef enum logic [1:0] {
    PH_RESET,
    PH_REF,
    PH_INTEGRATE,
    PH_HOLD
  } phase_t;

  typedef struct packed {
    logic reset;
    logic ctrl_a;
    logic ctrl_b;
  } section_ctrl_t;

  typedef struct packed {
    logic       acq_enable;
    logic       ecl_mode_input;
    logic       sampled_input_modes;
    logic       freq_output_enable;
    logic       timebase_fast_pulse;
    logic       readout_pulse;
  } ctrl_in_t;

endpackage

// ===== src/axil_regs.sv
/*
  AXI4-Lite slave holding the sequencer control word and returning status and count.
  Assumes one outstanding write and one outstanding read from the master.
*/
`timescale 1ns/100ps
module axil_regs
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // Write channels
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // Read channels
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Block side
  output logic [31:0]      ctrl,
  input  wire logic [31:0] status,
  input  wire logic [31:0] count
);

  logic [7:0]  awaddr_r, awaddr_nxt;
  logic        aw_have_r, aw_have_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0]  wstrb_r, wstrb_nxt;
  logic        w_have_r, w_have_nxt;
  logic        bvalid_r, bvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt;
  logic [31:0] ctrl_r, ctrl_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0]  rresp_r, rresp_nxt;

  always_comb
  begin
    awaddr_nxt  = awaddr_r;
    aw_have_nxt = aw_have_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    w_have_nxt  = w_have_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    ctrl_nxt    = ctrl_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    if (s_axi_awvalid && s_axi_awready)
    begin
      awaddr_nxt  = s_axi_awaddr;
      aw_have_nxt = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      wdata_nxt  = s_axi_wdata;
      wstrb_nxt  = s_axi_wstrb;
      w_have_nxt = 1'b1;
    end
    if (aw_have_r && w_have_r && !bvalid_r)
    begin
      aw_have_nxt = 1'b0;
      w_have_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = seq_pkg::RESP_OKAY;
      if ({awaddr_r[7:2], 2'b00} == seq_pkg::CTRL_OFS)
      begin
        for (int b = 0; b < 4; b++)
        begin
          if (wstrb_r[b])
          begin
            ctrl_nxt[b*8 +: 8] = wdata_r[b*8 +: 8];
          end
        end
      end
      else if ({awaddr_r[7:2], 2'b00} != seq_pkg::STATUS_OFS &&
               {awaddr_r[7:2], 2'b00} != seq_pkg::COUNT_OFS)
      begin
        bresp_nxt = seq_pkg::RESP_SLVERR;
      end
    end
    if (bvalid_r && s_axi_bready)
    begin
      bvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = seq_pkg::RESP_OKAY;
      unique case ({s_axi_araddr[7:2], 2'b00})
        seq_pkg::CTRL_OFS:   rdata_nxt = ctrl_r;
        seq_pkg::STATUS_OFS: rdata_nxt = status;
        seq_pkg::COUNT_OFS:  rdata_nxt = count;
        default:
        begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = seq_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_r && s_axi_rready)
    begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      awaddr_r  <= 8'h00;
      aw_have_r <= 1'b0;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      w_have_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= 2'h0;
      ctrl_r    <= seq_pkg::CTRL_RESET;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= 2'h0;
    end
    else
    begin
      awaddr_r  <= awaddr_nxt;
      aw_have_r <= aw_have_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      w_have_r  <= w_have_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      ctrl_r    <= ctrl_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  assign s_axi_awready = !aw_have_r && !bvalid_r;
  assign s_axi_wready  = !w_have_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign ctrl          = ctrl_r;

endmodule

// ===== src/ccd_shift_register_sequencer.sv
/*
  Sequencer for a two-section analog charge-coupled shift register: write and
  read windows, output stage resets, multiplexer phases and trim selects.
  Assumes pulse inputs are asynchronous pins much slower than core_clk.
*/
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
// Functional notes
// [RL1] Trim select 00 slow, 01 for 0.5us/div, 10 for 0.2us/div.
// [RL2] Section reset high before first phase boundary, low at it.
// [RL3] Between reset release and output clock rise, multiplexer at position 2.
// [RL4] From output clock rise to next boundary, multiplexer at position 3.
// [RL5] Final phase: address 1, multiplexer disabled, value held.
// [RL6] Second section phases run half a sample shifted from the first.
// [RL7] Register mode: second control line alternates sections onto converter.
// [RL8] Directly sampled modes route track-and-hold input to converter.
// [RL9] Window flip-flops move only while acquisition enable is high. The code also forces both windows high in ECL mode.
// [RL10] Write window low shifts samples in with fast-pulse derived clock.
// [RL11] Write window changes only on even fast pulses. The code also closes it in ECL mode.
// [RL12] Read window shifts out on readout pulse, changes only with it. The code also closes it in ECL mode.
// [RL13] Sequencing steps on fast pulse or readout pulse and its inverse.
// [RL14] ECL mode input high: sequencer idle, phase signal held high.
// [RL15] Write window high: controls and phase inhibited, resets held high. The code inhibits while write window is low instead.
// [RL16] Two sections of 128 stages; readout after all 256 filled.
// [RL17] Hold-convert from readout pulses, first one suppressed.
// [RL18] Pulses sampled as enables with edge detection in one clock.
module ccd_shift_register_sequencer
#(
  parameter int unsigned STAGES = seq_pkg::STAGES
)
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // Acquisition control pins
  input  wire logic        acq_enable,
  input  wire logic        ecl_mode_input,
  input  wire logic        sampled_input_modes,
  input  wire logic        freq_output_enable,
  input  wire logic        timebase_fast_pulse,
  input  wire logic        readout_pulse,
  // Register bus
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Register and clock driver side
  output logic             write_window_n,
  output logic             read_window_n,
  output logic             section_one_reset,
  output logic             section_two_reset,
  output logic             outmux_ctrl_a,
  output logic             outmux_ctrl_b,
  output logic             phase_drive,
  output logic             ccd_output_clock,
  output logic             clock_driver_drive,
  output logic             hold_convert_ccd,
  // Analog routing selects
  output logic             trim_sel_high,
  output logic             trim_sel_low,
  output logic             vout_sel_section_two,
  output logic             vout_sel_direct
);

  localparam int unsigned CW = $clog2(STAGES + 1);

  logic [31:0] ctrl;
  logic [31:0] status;
  logic [31:0] count;
  seq_pkg::ctrl_in_t pins;
  seq_pkg::ctrl_in_t lv;
  logic        tbf_rise;
  logic        ro_rise;
  logic        ro_fall;
  logic        ro_level;
  logic [5:0]  rises;

  assign pins = '{acq_enable, ecl_mode_input, sampled_input_modes,
                  freq_output_enable, timebase_fast_pulse, readout_pulse};

  // [RL18] synchronise every pin
  for (genvar i = 0; i < 6; i++)
  begin : g_sync
    pulse_edge u_sync
    (
      .core_clk (core_clk),
      .resetn   (resetn),
      .pin      (pins[i]),
      .level    (lv[i]),
      .rise     (rises[i])
    );
  end

  assign tbf_rise = rises[1];
  assign ro_rise  = rises[0];
  assign ro_level = lv.readout_pulse;

  axil_regs u_regs
  (
    .core_clk      (core_clk),
    .resetn        (resetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .ctrl          (ctrl),
    .status        (status),
    .count         (count)
  );

  logic        ro_prev_r, ro_prev_nxt;
  logic        tbf_half_r, tbf_half_nxt;
  logic        wr_n_r, wr_n_nxt;
  logic        rd_n_r, rd_n_nxt;
  logic [CW-1:0] wcnt_r, wcnt_nxt;
  logic [CW-1:0] rcnt_r, rcnt_nxt;
  logic        first_hc_r, first_hc_nxt;
  logic        hc_r, hc_nxt;
  logic        step;
  logic        armed;
  seq_pkg::phase_t ph_r, ph_nxt;
  seq_pkg::section_ctrl_t s1, s2;
  logic        inhibit;
  logic [1:0]  trim_r, trim_nxt;
  logic        sec_r, sec_nxt;

  assign ro_fall = ro_prev_r & ~ro_level;
  // [RL9] windows move only when armed or when ECL mode forces both high
  assign armed   = lv.acq_enable & lv.freq_output_enable & ~lv.sampled_input_modes;
  // [RL13] step on fast pulse while writing, else readout edges
  assign step    = !wr_n_r ? tbf_rise : (ro_rise | ro_fall);
  // [RL15] write window inhibits output sequencing
  assign inhibit = lv.ecl_mode_input | !wr_n_r;

  always_comb
  begin
    ro_prev_nxt  = ro_level;
    tbf_half_nxt = tbf_half_r ^ tbf_rise;
    wr_n_nxt     = wr_n_r;
    rd_n_nxt     = rd_n_r;
    wcnt_nxt     = wcnt_r;
    rcnt_nxt     = rcnt_r;
    first_hc_nxt = first_hc_r;
    hc_nxt       = 1'b0;
    ph_nxt       = ph_r;
    sec_nxt      = sec_r;
    trim_nxt     = trim_r;
    // [RL1] trim code from time base range
    unique case (ctrl[seq_pkg::CTRL_RANGE_LSB +: 2])
      seq_pkg::RANGE_500N: trim_nxt = seq_pkg::TRIM_500N;
      seq_pkg::RANGE_200N: trim_nxt = seq_pkg::TRIM_200N;
      default:             trim_nxt = seq_pkg::TRIM_SLOW;
    endcase
    if (lv.ecl_mode_input)
    begin
      // [RL14] whole sequencer idle
      wr_n_nxt = 1'b1;
      rd_n_nxt = 1'b1;
      ph_nxt   = seq_pkg::PH_RESET;
    end
    else if (armed)
    begin
      // [RL11] write window toggles only on even fast pulses or when ECL mode closes it
      if (tbf_rise && tbf_half_r)
      begin
        if (wr_n_r && rd_n_r && wcnt_r == '0)
        begin
          wr_n_nxt = 1'b0;
        end
        else if (!wr_n_r && wcnt_r == CW'(STAGES))
        begin
          // [RL16] all stages filled, readout may begin
          wr_n_nxt = 1'b1;
        end
      end
      // [RL10] fill counts fast pulse pairs, one per section pair
      if (!wr_n_r && tbf_rise && tbf_half_r && wcnt_r != CW'(STAGES))
      begin
        wcnt_nxt = wcnt_r + CW'(1);
      end
      // [RL12] read window follows readout pulse
      if (ro_rise)
      begin
        if (wr_n_r && rd_n_r && wcnt_r == CW'(STAGES))
        begin
          rd_n_nxt     = 1'b0;
          rcnt_nxt     = '0;
          first_hc_nxt = 1'b1;
        end
        else if (!rd_n_r)
        begin
          // [RL17] first hold-convert pulse suppressed
          hc_nxt       = !first_hc_r;
          first_hc_nxt = 1'b0;
          if (rcnt_r == CW'(STAGES))
          begin
            rd_n_nxt = 1'b1;
            wcnt_nxt = '0;
          end
          else
          begin
            rcnt_nxt = rcnt_r + CW'(1);
          end
        end
      end
    end
    if (inhibit)
    begin
      ph_nxt = seq_pkg::PH_RESET;
    end
    else if (step)
    begin
      unique case (ph_r)
        seq_pkg::PH_RESET:     ph_nxt = seq_pkg::PH_REF;
        seq_pkg::PH_REF:       ph_nxt = seq_pkg::PH_INTEGRATE;
        seq_pkg::PH_INTEGRATE: ph_nxt = seq_pkg::PH_HOLD;
        seq_pkg::PH_HOLD:
        begin
          ph_nxt  = seq_pkg::PH_RESET;
          sec_nxt = ~sec_r;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ro_prev_r  <= 1'b0;
      tbf_half_r <= 1'b0;
      wr_n_r     <= 1'b1;
      rd_n_r     <= 1'b1;
      wcnt_r     <= '0;
      rcnt_r     <= '0;
      first_hc_r <= 1'b0;
      hc_r       <= 1'b0;
      ph_r       <= seq_pkg::PH_RESET;
      sec_r      <= 1'b0;
      trim_r     <= seq_pkg::TRIM_SLOW;
    end
    else
    begin
      ro_prev_r  <= ro_prev_nxt;
      tbf_half_r <= tbf_half_nxt;
      wr_n_r     <= wr_n_nxt;
      rd_n_r     <= rd_n_nxt;
      wcnt_r     <= wcnt_nxt;
      rcnt_r     <= rcnt_nxt;
      first_hc_r <= first_hc_nxt;
      hc_r       <= hc_nxt;
      ph_r       <= ph_nxt;
      sec_r      <= sec_nxt;
      trim_r     <= trim_nxt;
    end
  end

  // Two bits of multiplexer address per phase; the second bit doubles as the
  // multiplexer enable, so hold uses address 1 with the enable low.
  function automatic seq_pkg::section_ctrl_t sect(input seq_pkg::phase_t p);
    seq_pkg::section_ctrl_t s;
    s = '{1'b0, 1'b0, 1'b0};
    unique case (p)
      // [RL2] reset high until first boundary
      seq_pkg::PH_RESET:     s = '{1'b1, 1'b0, 1'b0};
      // [RL3] position 2 captures reference
      seq_pkg::PH_REF:       s = '{1'b0, seq_pkg::MUX_POS_REF[0], seq_pkg::MUX_POS_REF[1]};
      // [RL4] position 3 integrates
      seq_pkg::PH_INTEGRATE: s = '{1'b0, seq_pkg::MUX_POS_INT[0], seq_pkg::MUX_POS_INT[1]};
      // [RL5] position 1, enable low, value held
      seq_pkg::PH_HOLD:      s = '{1'b0, seq_pkg::MUX_POS_HOLD[0], seq_pkg::MUX_POS_HOLD[1]};
    endcase
    return s;
  endfunction

  assign s1 = inhibit ? '{1'b1, 1'b0, 1'b0} : sect(ph_r);
  // [RL6] second section offset by two phases
  assign s2 = inhibit ? '{1'b1, 1'b0, 1'b0} : sect(seq_pkg::phase_t'(ph_r + 2'h2));

  assign write_window_n     = wr_n_r;
  assign read_window_n      = rd_n_r;
  assign section_one_reset  = s1.reset;
  assign section_two_reset  = s2.reset;
  assign outmux_ctrl_a      = s1.ctrl_a;
  assign outmux_ctrl_b      = s1.ctrl_b;
  // [RL14] phase signal high while idle
  assign phase_drive        = inhibit ? 1'b1 : ph_r[0];
  assign ccd_output_clock   = (ph_r == seq_pkg::PH_INTEGRATE) || (ph_r == seq_pkg::PH_HOLD);
  assign clock_driver_drive = !wr_n_r ? tbf_half_r : (!rd_n_r ? ro_level : 1'b0);
  assign hold_convert_ccd   = hc_r;
  assign trim_sel_high      = trim_r[1];
  assign trim_sel_low       = trim_r[0];
  // [RL8] direct input in sampled modes
  assign vout_sel_direct    = lv.sampled_input_modes | ctrl[seq_pkg::CTRL_DIRECT_BIT];
  // [RL7] held section select
  assign vout_sel_section_two = s1.ctrl_b;

  assign status = {24'h0, lv.ecl_mode_input, lv.acq_enable, ph_r, sec_r, first_hc_r,
                   rd_n_r, wr_n_r};
  assign count  = {16'h0, 8'(rcnt_r), 8'(wcnt_r)};

endmodule

// ===== src/pulse_edge.sv
/*
  Two-stage synchroniser followed by a rising edge detector.
  Assumes the input is asynchronous to core_clk and slower than it.
*/
`timescale 1ns/100ps
module pulse_edge
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic resetn,
  // Pin side
  input  wire logic pin,
  // Core side
  output logic      level,
  output logic      rise
);

  logic meta_r;
  logic sync_r;
  logic prev_r;
  logic meta_nxt;

  always_comb
  begin
    meta_nxt = pin;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level = sync_r;
  assign rise  = sync_r & ~prev_r;

endmodule

// ===== tb/ccd_register_model.sv
/*
  Far side model: time base pulse sources and the analog register sample count.
  Assumes pulses are free running and locked in phase to the core clock.
*/
`timescale 1ns/100ps
module ccd_register_model
(
  // Window controls
  input wire logic write_window_n,
  // Time base pulses
  output logic     timebase_fast_pulse,
  output logic     readout_pulse,
  // Samples taken in
  output int       written
);
  initial
  begin
    timebase_fast_pulse = 1'b0;
    readout_pulse = 1'b0;
    written = 0;
  end
  always #80 timebase_fast_pulse = ~timebase_fast_pulse;
  // Edges sit 5 ns off the core clock edges, so sampling never races them.
  initial #5 forever #170 readout_pulse = ~readout_pulse;
  always @(posedge timebase_fast_pulse)
    if (write_window_n === 1'b0) written = written + 1;
endmodule

// ===== tb/ccd_shift_register_sequencer_test.sv
/*
  Self-checking bench for the shift register sequencer.
  Assumes the design answers AXI4-Lite requests and the model drives the pulses.
*/
`timescale 1ns/100ps
module ccd_shift_register_sequencer_test;
  typedef struct packed {
    logic [31:0] wdata;
    logic [1:0]  trim;
    logic        direct;
  } row_t;
  logic core_clk = 1'b0, resetn = 1'b0;
  logic acq_enable = 1'b0, ecl_mode_input = 1'b0;
  logic sampled_input_modes = 1'b0, freq_output_enable = 1'b0;
  logic timebase_fast_pulse, readout_pulse;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic write_window_n, read_window_n, section_one_reset, section_two_reset;
  logic outmux_ctrl_a, outmux_ctrl_b, phase_drive, ccd_output_clock;
  logic clock_driver_drive, hold_convert_ccd, trim_sel_high, trim_sel_low;
  logic vout_sel_section_two, vout_sel_direct, sec_q = 1'b0;
  int errors = 0, num_checks = 0, written, hc_cnt = 0, sec_tog = 0, s0, n;
  row_t rows [4] = '{'{32'h0, seq_pkg::TRIM_SLOW, 1'b0}, '{32'h1, seq_pkg::TRIM_500N, 1'b0},
                     '{32'h2, seq_pkg::TRIM_200N, 1'b0}, '{32'h6, seq_pkg::TRIM_200N, 1'b1}};

  always #10 core_clk = ~core_clk;

  ccd_shift_register_sequencer ccd_shift_register_sequencer_inst (.core_clk, .resetn,
    .acq_enable, .ecl_mode_input, .sampled_input_modes, .freq_output_enable,
    .timebase_fast_pulse, .readout_pulse, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .write_window_n,
    .read_window_n, .section_one_reset, .section_two_reset, .outmux_ctrl_a, .outmux_ctrl_b,
    .phase_drive, .ccd_output_clock, .clock_driver_drive, .hold_convert_ccd,
    .trim_sel_high, .trim_sel_low, .vout_sel_section_two, .vout_sel_direct);

  ccd_register_model ccd_register_model_inst (.write_window_n, .timebase_fast_pulse,
    .readout_pulse, .written);

  always @(posedge core_clk)
  begin
    if (hold_convert_ccd === 1'b1) hc_cnt <= hc_cnt + 1;
    if (vout_sel_section_two !== sec_q) sec_tog <= sec_tog + 1;
    sec_q <= vout_sel_section_two;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    begin
      num_checks++;
      if (seen !== exp)
      begin
        errors++;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  // Answers are taken at the rising edge, before the design updates on it.
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    begin
      tb = 1'b0;
      @(posedge core_clk);
      if (wr)
      begin
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
      end
      else
      begin
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
      end
      while (!tb)
      begin
        @(posedge core_clk);
        ta = wr ? s_axi_awvalid && s_axi_awready : s_axi_arvalid && s_axi_arready;
        tw = s_axi_wvalid && s_axi_wready;
        tb = wr ? s_axi_bvalid : s_axi_rvalid;
        r = wr ? s_axi_bresp : s_axi_rresp;
        q = s_axi_rdata;
        if (ta && wr) s_axi_awvalid <= 1'b0;
        if (ta && !wr) s_axi_arvalid <= 1'b0;
        if (tw) s_axi_wvalid <= 1'b0;
        if (tb) s_axi_bready <= 1'b0;
        if (tb) s_axi_rready <= 1'b0;
      end
    end
  endtask

  task automatic complete_run;
    begin
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  initial
  begin
    #(20 * 40000);
    errors++;
    complete_run();
  end

  initial
  begin
    repeat (6) @(posedge core_clk);
    check({write_window_n, read_window_n, section_one_reset, section_two_reset, phase_drive},
          32'h1c);
    resetn <= 1'b1;
    axi(1'b0, seq_pkg::CTRL_OFS, 32'h0);
    check(q, seq_pkg::CTRL_RESET);
    $display("test reset done");
    foreach (rows[i])
    begin
      axi(1'b1, seq_pkg::CTRL_OFS, rows[i].wdata);
      axi(1'b0, seq_pkg::CTRL_OFS, 32'h0);
      check(q, rows[i].wdata);
      check({trim_sel_high, trim_sel_low}, rows[i].trim);
      check(vout_sel_direct, rows[i].direct);
    end
    $display("test table done");
    axi(1'b0, 8'h0c, 32'h0);
    check(q, 32'h0);
    check(r, seq_pkg::RESP_SLVERR);
    axi(1'b1, seq_pkg::STATUS_OFS, 32'hffff_ffff);
    check(r, seq_pkg::RESP_OKAY);
    axi(1'b1, seq_pkg::CTRL_OFS, 32'h0);
    $display("test bus errors done");
    acq_enable <= 1'b1;
    freq_output_enable <= 1'b1;
    for (n = 0; n < 9000 && write_window_n !== 1'b0; n++) @(posedge core_clk);
    for (n = 0; n < 9000 && write_window_n !== 1'b1; n++) @(posedge core_clk);
    check({31'h0, written >= 256 && written <= 258}, 32'h1);
    for (n = 0; n < 9000 && read_window_n !== 1'b0; n++) @(posedge core_clk);
    s0 = sec_tog;
    for (n = 0; n < 9000 && read_window_n !== 1'b1; n++) @(posedge core_clk);
    acq_enable <= 1'b0;
    repeat (2) @(posedge core_clk);
    check(hc_cnt, seq_pkg::STAGES);
    check({31'h0, sec_tog > s0}, 32'h1);
    $display("test acquisition done");
    ecl_mode_input <= 1'b1;
    repeat (6) @(posedge core_clk);
    check(phase_drive, 1'b1);
    check({outmux_ctrl_a, outmux_ctrl_b, section_one_reset, section_two_reset}, 32'h3);
    check({ccd_output_clock, clock_driver_drive}, 32'h0);
    ecl_mode_input <= 1'b0;
    sampled_input_modes <= 1'b1;
    repeat (6) @(posedge core_clk);
    check(vout_sel_direct, 1'b1);
    $display("test modes done");
    complete_run();
  end
endmodule

bind ccd_shift_register_sequencer seq_checker seq_checker_inst (.core_clk(core_clk),
  .resetn(resetn), .acq_enable(acq_enable), .ecl_mode_input(ecl_mode_input),
  .sampled_input_modes(sampled_input_modes), .readout_pulse(readout_pulse),
  .write_window_n(write_window_n), .read_window_n(read_window_n),
  .section_one_reset(section_one_reset), .section_two_reset(section_two_reset),
  .phase_drive(phase_drive), .hold_convert_ccd(hold_convert_ccd),
  .trim_sel_high(trim_sel_high), .trim_sel_low(trim_sel_low),
  .vout_sel_direct(vout_sel_direct));

// ===== tb/seq_assertions.sv
/*
  Checker for the shift register sequencer pins.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/100ps
module seq_checker
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Watched inputs
  input wire logic acq_enable,
  input wire logic ecl_mode_input,
  input wire logic sampled_input_modes,
  input wire logic readout_pulse,
  // Watched outputs
  input wire logic write_window_n,
  input wire logic read_window_n,
  input wire logic section_one_reset,
  input wire logic section_two_reset,
  input wire logic phase_drive,
  input wire logic hold_convert_ccd,
  input wire logic trim_sel_high,
  input wire logic trim_sel_low,
  input wire logic vout_sel_direct
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  a_trim_code: assert property (
    !(trim_sel_high && trim_sel_low)) else $error("trim select shows unused code");
  a_ecl_idle: assert property (
    ecl_mode_input [*5] |-> phase_drive) else $error("phase signal low in ecl mode");
  a_write_inhibit: assert property (
    !write_window_n |-> section_one_reset && section_two_reset)
    else $error("section reset low while writing");
  a_window_excl: assert property (
    write_window_n || read_window_n) else $error("write and read windows overlap");
  a_hold_pulse: assert property (
    hold_convert_ccd |-> !$past(read_window_n) ##1 !hold_convert_ccd)
    else $error("hold convert outside readout or too long");
  a_direct_route: assert property (
    sampled_input_modes [*5] |-> vout_sel_direct) else $error("direct input not routed");
  a_write_armed: assert property (
    $fell(write_window_n) |-> $past(acq_enable, 3) || $past(acq_enable, 4))
    else $error("write window opened while not enabled");
  a_read_sync: assert property (
    $fell(read_window_n) |-> $past(readout_pulse, 3) || $past(readout_pulse, 4))
    else $error("read window opened off the readout pulse");
endmodule
